// file: hdl/lfcd_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the
//          carrier detect control block
// Assumes: clk_sys at 25 MHz
// Notes:   included by the design file
`ifndef LFCD_DEFINES_SVH
`define LFCD_DEFINES_SVH

`define LFCD_ADDR_W         4
`define LFCD_OFF_MODE_CTRL  4'h0
`define LFCD_OFF_STATUS     4'h1
`define LFCD_OFF_IRQ_MASK   4'h2
`define LFCD_OFF_RX_STATE   4'h3

`define LFCD_BIT_DET_OUT    7
`define LFCD_BIT_ALT_EN     6
`define LFCD_BIT_SYNC_HI    5
`define LFCD_BIT_SYNC_LO    4
`define LFCD_BIT_CAR_MODE   3

`define LFCD_SYNC_RESET     2'h1
`define LFCD_CVT_RESET      4'h0
`define LFCD_CAR_MODE_RESET 1'h1

`define LFCD_CLK_HZ         25000000
`define LFCD_AZ_PERIOD_US   1000
`define LFCD_AZ_LEN_US      64
`define LFCD_AZ_PERIOD_CYC  ((`LFCD_CLK_HZ / 1000000) * `LFCD_AZ_PERIOD_US)
`define LFCD_AZ_LEN_CYC     ((`LFCD_CLK_HZ / 1000000) * `LFCD_AZ_LEN_US)
`define LFCD_CNT_W          11
// low cycles of the slicer, outside auto-zero, that count as a lost carrier;
// must stay above half a carrier period
`define LFCD_GAP_CYC        16

`endif

// file: hdl/lfcd_pkg.sv
// Purpose: types of the carrier detect control block
// Assumes: nothing
// Notes:   constants live in lfcd_defines.svh
package lfcd_pkg;
  typedef enum logic [1:0] {
    LFCD_IDLE     = 2'b00,
    LFCD_VALIDATE = 2'b01,
    LFCD_RX_ON    = 2'b10
  } lfcd_state_t;
endpackage

// file: hdl/lfcd_carrier_detect.sv
// Purpose: control register, mode alternation, carrier validation and
//          auto-zero scheduling of the low-frequency carrier detector
// Assumes: slicer output, sampling-on start and message end come from pins
//          or other clocks, so all pass two flip-flops
// Notes:   registers: 0 mode control, 1 status (write one to clear),
//          2 irq mask, 3 receive state (bit 3 carrier mode writable)
//
// How it works
// R1: bit 7 reads live slicer output
// R2: no reset touches the slicer bit
// R3: alternate enable flips mode each sampling start
// R4: alternate off holds mode; reset clears enable
// R5: sync field bits 5:4, reset 01
// R6: transmitter sends at least 2 ms preamble
// R7: carrier mode count reached sets found flag
// R8: found flag with enable raises interrupt
// R9: data mode powers receive chain after count
// R10: validated message ignores validate time field
// R11: reset clears validate time field
// R12: codes 0000-0110 carrier 8..512, data 8
// R13: codes 1000-1111 8..1024 both modes
// R14: auto-zero every 1 ms
// R15: auto-zero lasts 64 us, input ignored
// R16: carrier back after auto-zero counts throughout
// R17: mode bit one carrier, zero data
// R18: count slicer rising edges, restart on drop
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "lfcd_defines.svh"

module lfcd_carrier_detect
  import lfcd_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  // register port
  input  wire logic [`LFCD_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // detector side
  input  wire logic                    slicer_out,
  input  wire logic                    sampling_on_start,
  input  wire logic                    message_done,
  output logic                         rx_chain_power,
  output logic                         auto_zero_active,
  output logic                         detector_shutoff,
  // interrupt
  output logic                         irq
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:1] sync1_reg;
  logic [2:1] sync2_reg;
  logic       slice_m_reg;
  logic       slice_s_reg;
  logic       slice_d_reg;
  logic       start_d_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg   <= 2'h0;
      sync2_reg   <= 2'h0;
      start_d_reg <= 1'b0;
    end else begin
      sync1_reg   <= {message_done, sampling_on_start};
      sync2_reg   <= sync1_reg;
      start_d_reg <= sync2_reg[1];
    end
  end

  // slicer path is not reset, so the read bit follows the pin always
  always_ff @(posedge clk_sys) begin
    slice_m_reg <= slicer_out;
    slice_s_reg <= slice_m_reg;
    slice_d_reg <= slice_s_reg;
  end

  wire logic slice_s     = slice_s_reg;
  wire logic start_pulse = sync2_reg[1] & ~start_d_reg;
  wire logic msg_done_s  = sync2_reg[2];

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`LFCD_ADDR_W-1:0] a,
                               input logic [`LFCD_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  wire logic wr_ctrl  = reg_wr & hit(reg_addr, `LFCD_OFF_MODE_CTRL);
  wire logic wr_stat  = reg_wr & hit(reg_addr, `LFCD_OFF_STATUS);
  wire logic wr_mask  = reg_wr & hit(reg_addr, `LFCD_OFF_IRQ_MASK);
  wire logic wr_mode  = reg_wr & hit(reg_addr, `LFCD_OFF_RX_STATE);

  logic       alt_en_reg;
  logic [1:0] sync_sel_reg;
  logic [3:0] cvt_reg;
  logic       car_mode_reg;
  logic       found_reg;
  logic       mask_reg;
  logic       rx_on_reg;

  // ----------------------------------------------------------------
  // control register and carrier mode
  // ----------------------------------------------------------------
  wire logic car_mode_next = wr_mode     ? reg_wdata[`LFCD_BIT_CAR_MODE] :
                             (start_pulse & alt_en_reg) ? ~car_mode_reg  : // see R3
                             car_mode_reg;                                 // see R4

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alt_en_reg   <= 1'b0;                   // see R4
      sync_sel_reg <= `LFCD_SYNC_RESET;       // see R5
      cvt_reg      <= `LFCD_CVT_RESET;        // see R11
      car_mode_reg <= `LFCD_CAR_MODE_RESET;
      mask_reg     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        alt_en_reg   <= reg_wdata[`LFCD_BIT_ALT_EN];
        sync_sel_reg <= reg_wdata[`LFCD_BIT_SYNC_HI:`LFCD_BIT_SYNC_LO];
        cvt_reg      <= reg_wdata[3:0];
      end
      car_mode_reg <= car_mode_next;
      if (wr_mask) begin
        mask_reg <= reg_wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // auto-zero scheduler
  // ----------------------------------------------------------------
  logic [15:0] az_cnt_reg;
  logic        az_reg;
  wire logic   az_wrap = (az_cnt_reg == 16'(`LFCD_AZ_PERIOD_CYC - 1));
  wire logic   az_end  = (az_cnt_reg == 16'(`LFCD_AZ_LEN_CYC - 1));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      az_cnt_reg <= 16'h0000;
      az_reg     <= 1'b0;
    end else begin
      az_cnt_reg <= az_wrap ? 16'h0000 : az_cnt_reg + 16'h0001;  // see R14
      if (az_wrap) begin
        az_reg <= 1'b1;
      end else if (az_end) begin
        az_reg <= 1'b0;                                          // see R15
      end
    end
  end

  // ----------------------------------------------------------------
  // carrier validation
  // ----------------------------------------------------------------
  // period count per code: carrier mode and data mode columns
  function automatic logic [`LFCD_CNT_W-1:0] need_count(input logic [3:0] code,
                                                         input logic      carrier);
    logic [3:0] sh;
    sh = 4'h0;
    if (code[3]) begin
      sh = {1'b0, code[2:0]};                                    // see R13
    end else if (carrier) begin
      sh = (code[2:0] == 3'h7) ? 4'h6 : {1'b0, code[2:0]};       // see R12
    end
    need_count = `LFCD_CNT_W'(8) << sh;
  endfunction

  lfcd_state_t state_reg;
  logic [`LFCD_CNT_W-1:0] edge_cnt_reg;
  logic [`LFCD_CNT_W-1:0] target_reg;
  logic                   shut_reg;

  // during auto-zero the input is frozen; a carrier still high at the end
  // simply continues the run, so the gap counts as carrier time
  wire logic rise      = slice_s & ~slice_d_reg & ~az_reg;       // see R18
  // the sliced carrier is low half of each period, so only a low run longer
  // than that restarts the count; the run is frozen during auto-zero
  logic [4:0] low_cnt_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= 5'h00;
    end else if (slice_s) begin
      low_cnt_reg <= 5'h00;
    end else if (~az_reg && (low_cnt_reg < 5'(`LFCD_GAP_CYC))) begin
      low_cnt_reg <= low_cnt_reg + 5'h01;
    end
  end

  wire logic drop      = ~slice_s & ~az_reg &
                         (low_cnt_reg >= 5'(`LFCD_GAP_CYC));     // see R16
  wire logic reached   = rise & (edge_cnt_reg + 1'b1 >= target_reg);
  wire logic found_set = (state_reg == LFCD_VALIDATE) & reached & car_mode_reg; // see R7

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= LFCD_IDLE;
      edge_cnt_reg <= '0;
      target_reg   <= '0;
      rx_on_reg    <= 1'b0;
      shut_reg     <= 1'b0;
    end else begin
      case (state_reg)
        LFCD_IDLE: begin
          shut_reg <= 1'b0;
          if (start_pulse) begin
            target_reg   <= need_count(cvt_reg, car_mode_next);
            edge_cnt_reg <= '0;
            state_reg    <= LFCD_VALIDATE;
          end
        end
        LFCD_VALIDATE: begin
          if (drop) begin
            edge_cnt_reg <= '0;                                  // see R18
          end else if (reached) begin
            if (car_mode_reg) begin                              // see R17
              shut_reg  <= 1'b1;
              state_reg <= LFCD_IDLE;
            end else begin
              rx_on_reg <= 1'b1;                                 // see R9
              state_reg <= LFCD_RX_ON;
            end
          end else if (rise) begin
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
          end
        end
        LFCD_RX_ON: begin
          // field no longer consulted until the message ends
          if (msg_done_s) begin                                  // see R10
            rx_on_reg <= 1'b0;
            state_reg <= LFCD_IDLE;
          end
        end
        default: state_reg <= LFCD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status, interrupt and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      found_reg <= 1'b0;
      irq       <= 1'b0;
    end else begin
      // set wins over a simultaneous write-one clear
      found_reg <= found_set | (found_reg & ~(wr_stat & reg_wdata[0]));
      irq       <= (found_set | found_reg) & mask_reg;           // see R8
    end
  end

  wire logic [7:0] rd_ctrl = {slice_s, alt_en_reg, sync_sel_reg, cvt_reg}; // see R1 R2
  wire logic [7:0] rd_mux  =
    hit(reg_addr, `LFCD_OFF_MODE_CTRL) ? rd_ctrl :
    hit(reg_addr, `LFCD_OFF_STATUS)    ? {7'h00, found_reg} :
    hit(reg_addr, `LFCD_OFF_IRQ_MASK)  ? {7'h00, mask_reg} :
    hit(reg_addr, `LFCD_OFF_RX_STATE)  ? {4'h0, car_mode_reg, az_reg, state_reg} :
    8'h00;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata        <= 8'h00;
      rx_chain_power   <= 1'b0;
      auto_zero_active <= 1'b0;
      detector_shutoff <= 1'b0;
    end else begin
      reg_rdata        <= reg_rd ? rd_mux : 8'h00;
      rx_chain_power   <= rx_on_reg;
      auto_zero_active <= az_reg;
      detector_shutoff <= shut_reg;
    end
  end

endmodule

// file: test/lfcd_carrier_detect_sva.sv
// Purpose: port assertions of the carrier detect block
// Assumes: 25 MHz clk_sys
// Notes:   auto-zero timing judged from the first whole window
`timescale 1ns/1ps
module lfcd_chk (
  // clock, reset, register port
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // detector side
  input wire logic       rx_chain_power,
  input wire logic       auto_zero_active,
  input wire logic       detector_shutoff,
  input wire logic       irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] hi_cnt, per_cnt;
  logic        seen;
  wire         az_go = auto_zero_active && hi_cnt == 16'h0;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt  <= 16'h0;
      per_cnt <= 16'h0;
      seen    <= 1'b0;
    end else begin
      hi_cnt  <= auto_zero_active ? hi_cnt + 16'h1 : 16'h0;
      per_cnt <= az_go ? 16'h1 : per_cnt + 16'h1;
      seen    <= seen || az_go;
    end
  end
  sequence bad_rd;
    reg_rd && reg_addr > 4'h3;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (bad_rd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  shutoff_pulse_a: assert property (detector_shutoff |=> !detector_shutoff)
    else $error("shutoff too long");
  shutoff_mode_a: assert property (detector_shutoff |-> !rx_chain_power)
    else $error("shutoff with chain on");
  az_length_a: assert property ($fell(auto_zero_active) && seen |-> hi_cnt == 16'h0640)
    else $error("auto-zero length");
  az_period_a: assert property (az_go && seen |-> per_cnt == 16'h61A8)
    else $error("auto-zero period");
  irq_cause_a: assert property ($rose(irq) && !$past(reg_wr) &&
    !$past(reg_wr, 2) |=> detector_shutoff)
    else $error("interrupt without cause");
  irq_hold_a: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt dropped");
endmodule
bind lfcd_carrier_detect lfcd_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_chain_power(rx_chain_power), .auto_zero_active(auto_zero_active),
  .detector_shutoff(detector_shutoff), .irq(irq));

// file: test/lfcd_lf_src.sv
// Purpose: carrier at the slicer, 8 clocks a period
// Assumes: mode 0 silent, 1 carrier, 2 steady high
// Notes:   a silent slicer rests low, its no-carrier level
`timescale 1ns/1ps
module lfcd_lf_src (
  // control
  input wire logic       clk_sys,
  input wire logic [1:0] mode,
  // slicer level
  output logic           slicer_out
);
  logic [2:0] ph = 3'h0;
  always @(posedge clk_sys) ph <= (mode == 2'h1) ? ph + 3'h1 : 3'h0;
  assign slicer_out = mode == 2'h2 || (mode == 2'h1 && ph[2]);
endmodule

// file: test/tb.sv
// Purpose: bench of the carrier detect block
// Assumes: carrier of 8 clocks a period
// Notes:   validations run clear of auto-zero windows
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %0t %h %h", $time, (g), (e)); end end
module tb;
  logic       clk_sys, sys_rst, wr_s, rd_s, start, done, sl_q;
  logic [3:0] addr;
  logic [7:0] wd;
  logic [1:0] src;
  logic [3:0] dc [2] = '{4'h6, 4'hB};
  wire        slicer, rx_pw, az, shut, irq;
  wire  [7:0] rdat;
  int         err_total, num_checks, rises, gap;
  lfcd_carrier_detect dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .slicer_out(slicer),
    .sampling_on_start(start), .message_done(done), .rx_chain_power(rx_pw),
    .auto_zero_active(az), .detector_shutoff(shut), .irq(irq));
  lfcd_lf_src src_u (.clk_sys(clk_sys), .mode(src), .slicer_out(slicer));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    sl_q <= slicer;
    if (slicer && !sl_q) rises++;
    gap <= az ? 0 : gap + 1;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {addr, wd, wr_s} <= {a, d, 1'b1};
    @(posedge clk_sys);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    {addr, rd_s} <= {a, 1'b1};
    @(posedge clk_sys);
    rd_s <= 1'b0;
    #1 `CHK(rdat & m, e)
  endtask
  task automatic kick();
    @(posedge clk_sys);
    start <= 1'b1;
    repeat (4) @(posedge clk_sys);
    start <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // a whole count must fit before the next auto-zero window
  task automatic val(input logic [3:0] c, input logic car);
    int n, k;
    n = (c[3] || car) ? 8 << ((c == 4'h7) ? 6 : c[2:0]) : 8;
    wr(4'h0, {4'h1, c});
    wr(4'h3, {4'h0, car, 3'h0});
    while (az || gap + n * 8 > 23000) @(posedge clk_sys);
    kick();
    rises = 0;
    src <= 2'h1;
    for (k = 0; k < 9000 && !(car ? shut : rx_pw); k++) @(posedge clk_sys);
    src <= 2'h0;
    `CHK(rises, n)
    repeat (3) @(posedge clk_sys);
    `CHK(irq, car)
    rdc(4'h1, 8'hFF, {7'h0, car});
    wr(4'h1, 8'h01);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {wr_s, rd_s, start, done} = 4'h0;
    {addr, wd, src} = {4'h0, 8'h00, 2'h2};
    gap = 30000;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(4'h0, 8'hFF, 8'h90);
    src <= 2'h0;
    rdc(4'h3, 8'hFB, 8'h08);
    rdc(4'h9, 8'hFF, 8'h00);
    rdc(4'h0, 8'h80, 8'h00);
    wr(4'h2, 8'h01);
    for (int c = 0; c < 16; c++) val(c[3:0], 1'b1);
    foreach (dc[i]) begin
      val(dc[i], 1'b0);
      wr(4'h0, 8'h1F);
      `CHK(rx_pw, 1'b1)
      done <= 1'b1;
      repeat (6) @(posedge clk_sys);
      done <= 1'b0;
      `CHK(rx_pw, 1'b0)
    end
    wr(4'h3, 8'h08);
    wr(4'h0, 8'h50);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(4'h0, 8'h10);
      kick();
      rdc(4'h3, 8'h08, {4'h0, i != 0, 3'h0});
    end
    finish_test();
  end
  initial begin
    #4000000;
    err_total++;
    finish_test();
  end
endmodule
